/* src/iar_pkg.sv */
package iar_pkg;
   localparam logic [7:0] CTRL_OFFSET   = 8'hB0;
   localparam logic [7:0] OFFS_OFFSET   = 8'hB1;
   localparam logic [7:0] VALUE_OFFSET  = 8'hB2;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] OFFS_RESET    = 8'h00;
   localparam logic [7:0] VALUE_RESET   = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK  = 8'h3F;
   localparam int         SEL_LSB       = 2;
   localparam int         SEL_W         = 4;
   localparam int         AUTO_BIT      = 1;
   localparam int         READ_BIT      = 0;
   localparam int         NUM_TGT       = 6;
   localparam logic [3:0] SEL_PATGEN    = 4'h0;
   localparam logic [3:0] SEL_PORT0     = 4'h1;
   localparam logic [3:0] SEL_PORT1     = 4'h2;
   localparam logic [3:0] SEL_SHARED    = 4'h5;
   localparam logic [3:0] SEL_BOTH      = 4'h6;
   localparam logic [3:0] SEL_CSI       = 4'h7;
   localparam int         TGT_PATGEN    = 0;
   localparam int         TGT_PORT0     = 1;
   localparam int         TGT_PORT1     = 2;
   localparam int         TGT_SHARED    = 3;
   localparam int         TGT_CSI       = 4;
endpackage

/* src/iar_target_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module iar_target_decode (
   // Select code
   input  wire logic [3:0] sel_i,
   // Write and read enable vectors, one bit per target block
   output logic      [4:0] wr_en_o,
   output logic      [4:0] rd_en_o
);
   always_comb begin
      wr_en_o = 5'h00;
      rd_en_o = 5'h00;
      unique case (sel_i)
         iar_pkg::SEL_PATGEN: begin
            wr_en_o[iar_pkg::TGT_PATGEN] = 1'b1;
            rd_en_o[iar_pkg::TGT_PATGEN] = 1'b1;
         end
         iar_pkg::SEL_PORT0: begin
            wr_en_o[iar_pkg::TGT_PORT0] = 1'b1;
            rd_en_o[iar_pkg::TGT_PORT0] = 1'b1;
         end
         iar_pkg::SEL_PORT1: begin
            wr_en_o[iar_pkg::TGT_PORT1] = 1'b1;
            rd_en_o[iar_pkg::TGT_PORT1] = 1'b1;
         end
         iar_pkg::SEL_SHARED: begin
            wr_en_o[iar_pkg::TGT_SHARED] = 1'b1;
            rd_en_o[iar_pkg::TGT_SHARED] = 1'b1;
         end
         iar_pkg::SEL_BOTH: begin
            // Writes reach both ports; reads come from port 0
            wr_en_o[iar_pkg::TGT_PORT0] = 1'b1;
            wr_en_o[iar_pkg::TGT_PORT1] = 1'b1;
            rd_en_o[iar_pkg::TGT_PORT0] = 1'b1;
         end
         iar_pkg::SEL_CSI: begin
            wr_en_o[iar_pkg::TGT_CSI] = 1'b1;
            rd_en_o[iar_pkg::TGT_CSI] = 1'b1;
         end
         default: begin
            // Reserved codes reach nothing
            wr_en_o = 5'h00;
            rd_en_o = 5'h00;
         end
      endcase
   end
endmodule
`default_nettype wire

/* src/iar_window.sv */
// Functional notes
// - Control bits 5:2 select target block; codes 0,1,2,5,6,7 valid, rest reserved.
// - Auto-step adds one to the offset after each indirect read or write.
// - With read request set, writing the offset strobes a read of the target.
// - With auto-step and read request, each value read strobes the next read.
// - Offset register holds the eight-bit offset inside the selected block.
// - Value writes go to the target register; value reads return its contents.
`timescale 1ns/1ps
`default_nettype none
module iar_window #(
   parameter int TGT_N = iar_pkg::NUM_TGT - 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Host register port
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output logic      [7:0]       reg_rdata_o,
   // Internal target blocks
   output logic      [7:0]       tgt_offset_o,
   output logic      [7:0]       tgt_wdata_o,
   output logic      [TGT_N-1:0] tgt_wr_o,
   output logic      [TGT_N-1:0] tgt_rd_o,
   input  wire logic [7:0]       tgt_rdata_i [TGT_N]
);
   logic [7:0]       ctrl_ff;
   logic [7:0]       nxt_ctrl;
   logic [7:0]       offs_ff;
   logic [7:0]       nxt_offs;
   logic [7:0]       wdata_ff;
   logic [7:0]       nxt_wdata;
   logic [TGT_N-1:0] wr_ff;
   logic [TGT_N-1:0] nxt_wr;
   logic [TGT_N-1:0] rd_ff;
   logic [TGT_N-1:0] nxt_rd;
   logic [TGT_N-1:0] wr_en;
   logic [TGT_N-1:0] rd_en;
   logic [3:0]       sel;
   logic             auto_step;
   logic             rd_req;
   logic             hit_ctrl;
   logic             hit_offs;
   logic             hit_value;
   logic [7:0]       tgt_value;

   assign sel       = ctrl_ff[iar_pkg::SEL_LSB +: iar_pkg::SEL_W];
   assign auto_step = ctrl_ff[iar_pkg::AUTO_BIT];
   assign rd_req    = ctrl_ff[iar_pkg::READ_BIT];
   assign hit_ctrl  = (reg_addr_i == iar_pkg::CTRL_OFFSET);
   assign hit_offs  = (reg_addr_i == iar_pkg::OFFS_OFFSET);
   assign hit_value = (reg_addr_i == iar_pkg::VALUE_OFFSET);

   iar_target_decode u_decode (
      .sel_i   (sel),
      .wr_en_o (wr_en),
      .rd_en_o (rd_en)
   );

   // Value of the selected block; zero when nothing is selected
   always_comb begin
      tgt_value = 8'h00;
      for (int i = 0; i < TGT_N; i++) begin
         if (rd_en[i]) begin
            tgt_value = tgt_rdata_i[i];
         end
      end
   end

   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_offs  = offs_ff;
      nxt_wdata = wdata_ff;
      nxt_wr    = '0;
      nxt_rd    = '0;
      if (reg_wr_i && hit_ctrl) begin
         nxt_ctrl = reg_wdata_i & iar_pkg::CTRL_WR_MASK;
      end
      if (reg_wr_i && hit_offs) begin
         nxt_offs = reg_wdata_i;
         if (rd_req) begin
            nxt_rd = rd_en;
         end
      end
      if (reg_wr_i && hit_value) begin
         nxt_wdata = reg_wdata_i;
         nxt_wr    = wr_en;
      end
      if (reg_rd_i && hit_value && auto_step && rd_req) begin
         nxt_rd = rd_en;
      end
      if (auto_step && hit_value && (reg_wr_i || reg_rd_i)) begin
         nxt_offs = 8'(offs_ff + 8'h01);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff  <= iar_pkg::CTRL_RESET;
         offs_ff  <= iar_pkg::OFFS_RESET;
         wdata_ff <= iar_pkg::VALUE_RESET;
         wr_ff    <= '0;
         rd_ff    <= '0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         offs_ff  <= nxt_offs;
         wdata_ff <= nxt_wdata;
         wr_ff    <= nxt_wr;
         rd_ff    <= nxt_rd;
      end
   end

   // Write strobes carry the offset before the step; a prefetch after a value
   // read carries the stepped offset, so the next register is fetched
   logic [7:0] strobe_offs_ff;
   logic [7:0] nxt_strobe_offs;

   always_comb begin
      nxt_strobe_offs = nxt_offs;
      if (reg_wr_i && hit_value) begin
         nxt_strobe_offs = offs_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         strobe_offs_ff <= iar_pkg::OFFS_RESET;
      end else begin
         strobe_offs_ff <= nxt_strobe_offs;
      end
   end

   assign tgt_offset_o = strobe_offs_ff;
   assign tgt_wdata_o  = wdata_ff;
   assign tgt_wr_o     = wr_ff;
   assign tgt_rd_o     = rd_ff;

   always_comb begin
      reg_rdata_o = 8'h00;
      if (hit_ctrl) begin
         reg_rdata_o = ctrl_ff;
      end else if (hit_offs) begin
         reg_rdata_o = offs_ff;
      end else if (hit_value) begin
         reg_rdata_o = tgt_value;
      end
   end

   property p_offs_write_prefetch;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_offs && rd_req && |rd_en) |=> (tgt_rd_o == $past(rd_en));
   endproperty
   a_offs_write_prefetch: assert property (p_offs_write_prefetch) else $error("no fetch");

   property p_value_read_prefetch;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_rd_i && hit_value && auto_step && rd_req && |rd_en) |=> (tgt_rd_o == $past(rd_en));
   endproperty
   a_value_read_prefetch: assert property (p_value_read_prefetch) else $error("no reread");

   property p_auto_step;
      @(posedge clk_i) disable iff (!rst_n_i)
         (auto_step && hit_value && (reg_wr_i || reg_rd_i) && !(reg_wr_i && (hit_ctrl || hit_offs)))
            |=> (offs_ff == $past(offs_ff) + 8'h01);
   endproperty
   a_auto_step: assert property (p_auto_step) else $error("offset not stepped");

   property p_value_write;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_value) |=> (tgt_wdata_o == $past(reg_wdata_i) && tgt_wr_o == $past(wr_en));
   endproperty
   a_value_write: assert property (p_value_write) else $error("write lost");

   property p_reserved_quiet;
      @(posedge clk_i) disable iff (!rst_n_i)
         (sel > iar_pkg::SEL_CSI || sel == 4'h3 || sel == 4'h4) |=>
            (tgt_wr_o == '0 && tgt_rd_o == '0);
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("strobe on reserved");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (!rst_n_i)
         (hit_value && (sel == 4'h3 || sel == 4'h4 || sel > iar_pkg::SEL_CSI)) |->
            (reg_rdata_o == 8'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");

   property p_offs_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_offs) |=> (offs_ff == $past(reg_wdata_i));
   endproperty
   a_offs_hold: assert property (p_offs_hold) else $error("offset not stored");

   property p_both_ports;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_value && sel == iar_pkg::SEL_BOTH) |=>
            (tgt_wr_o[iar_pkg::TGT_PORT0] && tgt_wr_o[iar_pkg::TGT_PORT1]);
   endproperty
   a_both_ports: assert property (p_both_ports) else $error("dual write missed");

   property p_prefetch_offs;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_rd_i && hit_value && auto_step && rd_req && |rd_en) |=>
            (tgt_offset_o == 8'($past(offs_ff) + 8'h01));
   endproperty
   a_prefetch_offs: assert property (p_prefetch_offs) else $error("bad next offset");

   property p_write_offs;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_value && |wr_en) |=> (tgt_offset_o == $past(offs_ff));
   endproperty
   a_write_offs: assert property (p_write_offs) else $error("bad write offset");

   property p_fetch_offs;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_offs && rd_req && |rd_en) |=> (tgt_offset_o == $past(reg_wdata_i));
   endproperty
   a_fetch_offs: assert property (p_fetch_offs) else $error("bad fetch offset");

   property p_ctrl_store;
      @(posedge clk_i) disable iff (!rst_n_i)
         (reg_wr_i && hit_ctrl) |=>
            (ctrl_ff == ($past(reg_wdata_i) & iar_pkg::CTRL_WR_MASK));
   endproperty
   a_ctrl_store: assert property (p_ctrl_store) else $error("control not stored");

   property p_offs_still;
      @(posedge clk_i) disable iff (!rst_n_i)
         (!auto_step && !(reg_wr_i && hit_offs)) |=> (offs_ff == $past(offs_ff));
   endproperty
   a_offs_still: assert property (p_offs_still) else $error("offset moved");

   property p_both_read;
      @(posedge clk_i) disable iff (!rst_n_i)
         (hit_value && sel == iar_pkg::SEL_BOTH) |->
            (reg_rdata_o == tgt_rdata_i[iar_pkg::TGT_PORT0]);
   endproperty
   a_both_read: assert property (p_both_read) else $error("dual read wrong");
endmodule
`default_nettype wire

/* dv/indirect_register_access_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module indirect_register_access_tb_top;
   logic       clk_i       = 1'b0;
   logic       rst_n_i     = 1'b0;
   logic [7:0] reg_addr_i  = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i    = 1'b0;
   logic       reg_rd_i    = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [7:0] tgt_offset_o;
   logic [7:0] tgt_wdata_o;
   logic [4:0] tgt_wr_o;
   logic [4:0] tgt_rd_o;
   logic [7:0] tdat [5]   = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int         errors     = 0;
   int         num_checks = 0;

   iar_window #(.TGT_N(5)) dut (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_rdata_o  (reg_rdata_o),
      .tgt_offset_o (tgt_offset_o),
      .tgt_wdata_o  (tgt_wdata_o),
      .tgt_wr_o     (tgt_wr_o),
      .tgt_rd_o     (tgt_rd_o),
      .tgt_rdata_i  (tdat)
   );

   always #12.5 clk_i = ~clk_i;

   function automatic logic [4:0] wmask(logic [3:0] s);
      case (s)
         4'h0: wmask = 5'h01;
         4'h1: wmask = 5'h02;
         4'h2: wmask = 5'h04;
         4'h5: wmask = 5'h08;
         4'h6: wmask = 5'h06;
         4'h7: wmask = 5'h10;
         default: wmask = 5'h00;
      endcase
   endfunction

   // Both-ports code reads back from port 0
   function automatic logic [4:0] rmask(logic [3:0] s);
      rmask = (s == 4'h6) ? 5'h02 : wmask(s);
   endfunction

   function automatic logic [7:0] rval(logic [3:0] s);
      logic [4:0] msk;
      msk  = rmask(s);
      rval = 8'h00;
      for (int k = 0; k < 5; k++) begin
         if (msk[k]) begin
            rval = tdat[k];
         end
      end
   endfunction

   task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask

   task automatic host_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      #1;
      v = reg_rdata_o;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #(25 * 100000);
      errors++;
      conclude();
   end

   initial begin : main
      logic [7:0] n, d, v, t;
      logic [3:0] s;
      logic [1:0] m;
      void'($urandom(70807));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      host_rd(iar_pkg::CTRL_OFFSET, v);
      `CHK(v, iar_pkg::CTRL_RESET)
      host_rd(iar_pkg::OFFS_OFFSET, v);
      `CHK(v, iar_pkg::OFFS_RESET)
      host_rd(8'hB3, v);
      `CHK(v, 8'h00)
      for (int i = 0; i < 64; i++) begin
         s = i[5:2];
         m = i[1:0];
         t = 8'($urandom);
         @(posedge clk_i);
         for (int k = 0; k < 5; k++) begin
            tdat[k] <= 8'($urandom);
         end
         host_wr(iar_pkg::CTRL_OFFSET, {t[7:6], s, m});
         host_rd(iar_pkg::CTRL_OFFSET, v);
         `CHK(v, {2'h0, s, m})
         n = (i % 8 == 0) ? 8'hFF : 8'($urandom);
         host_wr(iar_pkg::OFFS_OFFSET, n);
         `CHK(tgt_rd_o, m[0] ? rmask(s) : 5'h00)
         `CHK(tgt_offset_o, n)
         d = 8'($urandom);
         host_wr(iar_pkg::VALUE_OFFSET, d);
         `CHK(tgt_wr_o, wmask(s))
         `CHK(tgt_rd_o, 5'h00)
         if (wmask(s) != 5'h00) begin
            `CHK(tgt_wdata_o, d)
            `CHK(tgt_offset_o, n)
         end
         host_rd(iar_pkg::OFFS_OFFSET, v);
         `CHK(v, 8'(n + m[1]))
         host_rd(iar_pkg::VALUE_OFFSET, v);
         `CHK(v, rval(s))
         `CHK(tgt_rd_o, (m == 2'h3) ? rmask(s) : 5'h00)
         `CHK(tgt_offset_o, 8'(n + 2 * m[1]))
         `CHK(tgt_wr_o, 5'h00)
         host_rd(iar_pkg::OFFS_OFFSET, v);
         `CHK(v, 8'(n + 2 * m[1]))
      end
      // Mid-run reset returns the window to its reset state
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      host_rd(iar_pkg::CTRL_OFFSET, v);
      `CHK(v, iar_pkg::CTRL_RESET)
      host_rd(iar_pkg::OFFS_OFFSET, v);
      `CHK(v, iar_pkg::OFFS_RESET)
      conclude();
   end
endmodule
`default_nettype wire
